// *** rtl/fwa_cfg.svh ***
`ifndef FWA_CFG_SVH
`define FWA_CFG_SVH

// Register byte addresses on the APB slave.
`define FWA_A_OPER 8'h00
`define FWA_A_CLEAR 8'h04
`define FWA_A_STATUS 8'h08
`define FWA_A_MASK1 8'h0c
`define FWA_A_MASK2 8'h10
`define FWA_A_ACTL 8'h14
`define FWA_A_MON 8'h18
`define FWA_A_LIM0 8'h1c
`define FWA_A_OWN 8'h38
`define FWA_A_RD0 8'h3c

// Counts of indexed registers.
`define FWA_LIM_N 4'd7
`define FWA_RD_N 4'd5

// Reset values.
`define FWA_OPER_RST 8'h80
`define FWA_MON_RST 4'hf
`define FWA_OWN_RST 7'h2a
`define FWA_LIM_RST {16'h7fff, 16'h0fff, 16'h0fff, 16'h0000, 16'h0fff, 16'h0000, 16'h0fff}

// Field positions.
`define FWA_ON_BIT 7
`define FWA_ST_W 15
`define FWA_FLT_N 5
`define FWA_ST_CML 5
`define FWA_ST_BRK 6
`define FWA_ST_IOC 7
`define FWA_ST_VINUV 8
`define FWA_ST_VINOV 9
`define FWA_ST_VOUV 10
`define FWA_ST_VOOV 11
`define FWA_ST_POP 12
`define FWA_ST_OT 13
`define FWA_ST_HYS 14

// Alert response address 0x0c followed by the read bit.
`define FWA_ARA_BYTE 8'h19

`endif

// *** rtl/fwa_pkg.sv ***
`default_nettype none

`include "fwa_cfg.svh"

package fwa_pkg;

  typedef enum logic [2:0] {ARA_IDLE, ARA_ADDR, ARA_ACK, ARA_TX, ARA_NACK} fwa_ara_e;

  typedef logic [`FWA_ST_W-1:0] fwa_status_t;

endpackage

`default_nettype wire

// *** rtl/fwa_ara_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface fwa_ara_if;
  logic scl_s;
  logic sda_s;
  logic pending;
  logic [6:0] own_addr;
  logic won;
  logic sda_oe;

  modport top (output scl_s, output sda_s, output pending, output own_addr,
               input won, input sda_oe);
  modport ara (input scl_s, input sda_s, input pending, input own_addr,
               output won, output sda_oe);
endinterface

`default_nettype wire

// *** rtl/fwa_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module fwa_sync #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

`default_nettype wire

// *** rtl/fwa_ara.sv ***
`timescale 1ns/1ps
`default_nettype none

module fwa_ara
  import fwa_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  fwa_ara_if.ara bus
);

  fwa_ara_e st_q;
  logic [3:0] cnt_q;
  logic [6:0] sh_q;
  logic oe_q;
  logic scl_q;
  logic sda_q;
  logic won_q;

  wire scl_rise = bus.scl_s & ~scl_q;
  wire scl_fall = ~bus.scl_s & scl_q;
  wire start_c = scl_q & bus.scl_s & sda_q & ~bus.sda_s;
  wire stop_c = scl_q & bus.scl_s & ~sda_q & bus.sda_s;
  wire [7:0] tx_byte = {bus.own_addr, 1'b1};
  wire [2:0] tx_idx = 3'(4'd7 - cnt_q);
  wire [7:0] rx_byte = {sh_q, bus.sda_s};
  wire lost = scl_rise & ~oe_q & ~bus.sda_s;

  assign bus.won = won_q;
  assign bus.sda_oe = oe_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= bus.scl_s;
      sda_q <= bus.sda_s;
    end
  end

  // Answers a read of the alert response address with the own address.
  always_ff @(posedge clk)
  begin
    won_q <= 1'b0;
    if (srst)
    begin
      st_q <= ARA_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 7'h00;
      oe_q <= 1'b0;
    end
    else if (stop_c)
    begin
      st_q <= ARA_IDLE;
      oe_q <= 1'b0;
    end
    else if (start_c)
    begin
      st_q <= ARA_ADDR;
      cnt_q <= 4'h0;
      oe_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ARA_ADDR:
          if (scl_rise)
          begin
            sh_q <= rx_byte[6:0];
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h7)
              st_q <= (rx_byte == `FWA_ARA_BYTE && bus.pending) ? ARA_ACK : ARA_IDLE;
          end
        ARA_ACK:
          if (scl_fall)
          begin
            if (!oe_q)
              oe_q <= 1'b1;
            else
            begin
              oe_q <= ~tx_byte[7];
              cnt_q <= 4'h0;
              st_q <= ARA_TX;
            end
          end
        ARA_TX:
          if (lost)
            st_q <= ARA_IDLE;
          else if (scl_rise)
            cnt_q <= cnt_q + 4'h1;
          else if (scl_fall)
          begin
            if (cnt_q == 4'h8)
            begin
              oe_q <= 1'b0;
              st_q <= ARA_NACK;
            end
            else
              oe_q <= ~tx_byte[tx_idx];
          end
        ARA_NACK:
          if (scl_rise)
          begin
            won_q <= 1'b1;
            st_q <= ARA_IDLE;
          end
        default:
          st_q <= ARA_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// *** rtl/fwa_top.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "fwa_cfg.svh"

// Operation
// - Fault detection runs always; no register can mask it.
// - Any fault turns the hot swap output off.
// - Each fault sets its matching status bit.
// - Status bit value one means fault or warning present.
// - Status bits latch once set until explicitly cleared.
// - Clear-faults or off-then-on clears bits whose condition has ceased.
// - Warnings only set status bits, never change hot swap state.
// - Warnings: comm error, breaker trip, monitor limits, hysteretic output.
// - After reset both alert outputs float, with all alert enables off.
// - Each alert output has its own fault and warning enable mask.
// - Alert outputs are active low unless inverted per output.
// - Output undervoltage warning needs output voltage sampling enabled.
// - Alerts assert independently but always deassert together; a bit rising in the release cycle keeps asserted any alert that enables it.
// - Clear-faults clears status and deasserts both alerts; a bit rising in the clear cycle keeps asserted any alert that enables it.
// - A persisting fault stays set but does not reassert alerts.
// - A persisting monitor warning alerts again on next sample after clear.
// - While alerting, answer the response read with own 7-bit address.
// - Bitwise arbitration; lowest address wins and only it releases alert.
// - Current readings are raw 12-bit codes, 2048 means zero.
// - Voltage readings are raw 12-bit codes of 5.104 mV steps.
// - Winner releases its alert during the not-acknowledge bit.
// - Released alert reasserts only on a new enabled zero-to-one status bit.
module fwa_top
  import fwa_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`FWA_FLT_N-1:0] fault_pin,
  input wire logic breaker_trip_flag,
  input wire logic hyst_warn_pin,
  input wire logic mon_sample,
  input wire logic [11:0] input_voltage_reading,
  input wire logic [11:0] output_voltage_reading,
  input wire logic [11:0] load_current_reading,
  input wire logic [11:0] mon_temp_reading,
  input wire logic [15:0] mon_power_reading,
  input wire logic smb_scl,
  input wire logic smb_sda_in,
  output logic smb_sda_out,
  output logic smb_sda_oe,
  output logic first_alert_output_out,
  output logic first_alert_output_oe,
  output logic second_alert_output_out,
  output logic second_alert_output_oe,
  output logic hs_gate_on
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and the alert response responder.

  logic [8:0] pin_s;

  fwa_sync #(.W(9)) fwa_sync_inst (
    .clk(clk),
    .srst(srst),
    .d({smb_sda_in, smb_scl, hyst_warn_pin, breaker_trip_flag, fault_pin}),
    .q(pin_s)
  );

  fwa_ara_if ara_if ();

  fwa_ara fwa_ara_inst (
    .clk(clk),
    .srst(srst),
    .bus(ara_if.ara)
  );

  wire [`FWA_FLT_N-1:0] fault_live = pin_s[4:0];
  wire brk_live = pin_s[5];
  wire hys_live = pin_s[6];

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic on_q;
  fwa_status_t status_q;
  fwa_status_t status_d;
  fwa_status_t mask1_q;
  fwa_status_t mask2_q;
  logic [1:0] inv_q;
  logic [3:0] mon_q;
  logic [6:0] own_q;
  logic [15:0] lim_q [0:6];
  logic [15:0] rd_q [0:4];
  logic [1:0] alert_q;
  logic [1:0] alert_d;
  logic [31:0] prdata_q;
  logic err_q;
  logic hs_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  function automatic logic in_rng(input logic [7:0] a, input logic [7:0] base,
                                  input logic [3:0] n);
    logic [7:0] off;
    off = a - base;
    in_rng = (a[1:0] == 2'b00) && (a >= base) && (off[7:2] < {2'b00, n});
  endfunction

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_oper = paddr == `FWA_A_OPER;
  wire hit_clear = paddr == `FWA_A_CLEAR;
  wire hit_status = paddr == `FWA_A_STATUS;
  wire hit_mask1 = paddr == `FWA_A_MASK1;
  wire hit_mask2 = paddr == `FWA_A_MASK2;
  wire hit_actl = paddr == `FWA_A_ACTL;
  wire hit_mon = paddr == `FWA_A_MON;
  wire hit_own = paddr == `FWA_A_OWN;
  wire hit_lim = in_rng(paddr, `FWA_A_LIM0, `FWA_LIM_N);
  wire hit_rd = in_rng(paddr, `FWA_A_RD0, `FWA_RD_N);
  wire [7:0] lim_off = paddr - `FWA_A_LIM0;
  wire [7:0] rd_off = paddr - `FWA_A_RD0;
  wire [2:0] lim_idx = lim_off[4:2];
  wire [2:0] rd_idx = rd_off[4:2];
  wire wr_ok = hit_oper | hit_clear | hit_mask1 | hit_mask2 | hit_actl | hit_mon
             | hit_own | hit_lim;
  wire rd_ok = hit_oper | hit_status | hit_mask1 | hit_mask2 | hit_actl | hit_mon
             | hit_own | hit_lim | hit_rd;
  wire bad = pwrite ? ~wr_ok : ~rd_ok;
  wire wr = access & pwrite & ~err_q;
  wire cml_ev = access & err_q;

  wire [31:0] rdata =
      hit_oper ? {24'h0, on_q, 7'h00} :
      hit_status ? {17'h0, status_q} :
      hit_mask1 ? {17'h0, mask1_q} :
      hit_mask2 ? {17'h0, mask2_q} :
      hit_actl ? {22'h0, alert_q, 6'h00, inv_q} :
      hit_mon ? {28'h0, mon_q} :
      hit_own ? {25'h0, own_q} :
      hit_lim ? {16'h0, lim_q[lim_idx]} :
      hit_rd ? {16'h0, rd_q[rd_idx]} : 32'h0;

  assign pready = access;
  assign pslverr = access & err_q;
  assign prdata = prdata_q;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prdata_q <= 32'h0;
      err_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= pwrite ? 32'h0 : rdata;
      err_q <= bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; every alert enable is off after reset.

  wire on_wr = wr & hit_oper;
  wire on_rise = on_wr & pwdata[`FWA_ON_BIT] & ~on_q;
  wire clr = (wr & hit_clear) | on_rise;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      on_q <= 1'(`FWA_OPER_RST >> `FWA_ON_BIT);
      mask1_q <= '0;
      mask2_q <= '0;
      inv_q <= 2'b00;
      mon_q <= `FWA_MON_RST;
      own_q <= `FWA_OWN_RST;
    end
    else
    begin
      if (on_wr)
        on_q <= pwdata[`FWA_ON_BIT];
      if (wr & hit_mask1)
        mask1_q <= pwdata[`FWA_ST_W-1:0];
      if (wr & hit_mask2)
        mask2_q <= pwdata[`FWA_ST_W-1:0];
      if (wr & hit_actl)
        inv_q <= pwdata[1:0];
      if (wr & hit_mon)
        mon_q <= pwdata[3:0];
      if (wr & hit_own)
        own_q <= pwdata[6:0];
    end
  end

  localparam logic [111:0] LIM_RST = `FWA_LIM_RST;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_lim
      always_ff @(posedge clk)
      begin
        if (srst)
          lim_q[gi] <= LIM_RST[gi*16 +: 16];
        else if (wr & hit_lim & (lim_idx == 3'(gi)))
          lim_q[gi] <= pwdata[15:0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Monitor samples and limit comparisons, all strict.

  wire s_vin = mon_sample & mon_q[0];
  wire s_vout = mon_sample & mon_q[1];
  wire s_iout = mon_sample & mon_q[2];
  wire s_temp = mon_sample & mon_q[3];
  wire s_pow = mon_sample & mon_q[0] & mon_q[2];
  wire [15:0] vin_w = {4'h0, input_voltage_reading};
  wire [15:0] vout_w = {4'h0, output_voltage_reading};
  wire [15:0] iout_w = {4'h0, load_current_reading};
  wire [15:0] temp_w = {4'h0, mon_temp_reading};

  wire w_vinov = s_vin & (vin_w > lim_q[0]);
  wire w_vinuv = s_vin & (vin_w < lim_q[1]);
  wire w_voov = s_vout & (vout_w > lim_q[2]);
  wire w_vouv = s_vout & (vout_w < lim_q[3]);
  wire w_ioc = s_iout & (iout_w > lim_q[4]);
  wire w_ot = s_temp & (temp_w > lim_q[5]);
  wire w_pop = s_pow & (mon_power_reading > lim_q[6]);

  // Readings keep the raw converter codes.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 5; i++)
        rd_q[i] <= 16'h0000;
    end
    else
    begin
      if (s_vin)
        rd_q[0] <= vin_w;
      if (s_vout)
        rd_q[1] <= vout_w;
      if (s_iout)
        rd_q[2] <= iout_w;
      if (s_temp)
        rd_q[3] <= temp_w;
      if (s_pow)
        rd_q[4] <= mon_power_reading;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status latching.

  fwa_status_t set_now;

  always_comb
  begin
    set_now = '0;
    set_now[`FWA_FLT_N-1:0] = fault_live;
    set_now[`FWA_ST_CML] = cml_ev;
    set_now[`FWA_ST_BRK] = brk_live;
    set_now[`FWA_ST_IOC] = w_ioc;
    set_now[`FWA_ST_VINUV] = w_vinuv;
    set_now[`FWA_ST_VINOV] = w_vinov;
    set_now[`FWA_ST_VOUV] = w_vouv;
    set_now[`FWA_ST_VOOV] = w_voov;
    set_now[`FWA_ST_POP] = w_pop;
    set_now[`FWA_ST_OT] = w_ot;
    set_now[`FWA_ST_HYS] = hys_live;
  end

  // A clear keeps only conditions still present; a set in that cycle wins.
  assign status_d = clr ? set_now : (status_q | set_now);

  always_ff @(posedge clk)
  begin
    if (srst)
      status_q <= '0;
    else
      status_q <= status_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert outputs.

  wire [`FWA_ST_W-1:0] rising = set_now & ~status_q;
  wire new1 = |(rising & mask1_q);
  wire new2 = |(rising & mask2_q);
  wire release_all = clr | ara_if.won;

  assign alert_d[0] = (alert_q[0] & ~release_all) | new1;
  assign alert_d[1] = (alert_q[1] & ~release_all) | new2;

  always_ff @(posedge clk)
  begin
    if (srst)
      alert_q <= 2'b00;
    else
      alert_q <= alert_d;
  end

  // Open drain: the pin is driven low whenever the level must be low.
  assign first_alert_output_out = 1'b0;
  assign second_alert_output_out = 1'b0;
  assign first_alert_output_oe = alert_q[0] ^ inv_q[0];
  assign second_alert_output_oe = alert_q[1] ^ inv_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Alert response link and hot swap gate.

  assign ara_if.scl_s = pin_s[7];
  assign ara_if.sda_s = pin_s[8];
  assign ara_if.pending = |alert_q;
  assign ara_if.own_addr = own_q;
  assign smb_sda_out = 1'b0;
  assign smb_sda_oe = ara_if.sda_oe;

  // Only the on bit and fault bits gate the output; warnings never reach it.
  always_ff @(posedge clk)
  begin
    if (srst)
      hs_q <= 1'b0;
    else
      hs_q <= on_q & ~|status_q[`FWA_FLT_N-1:0] & ~|fault_live;
  end

  assign hs_gate_on = hs_q;

endmodule

`default_nettype wire

// *** tb/fwa_host.sv ***
`timescale 1ns/1ps
`default_nettype none

// Bus host that issues alert response reads; the data line has a pull-up.
module fwa_host (
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic pull;
  assign sda = !(sda_oe || pull);
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end

  // One bit slot: data set while the clock is low, sampled late in the high half.
  task automatic bit_io(input logic b, output logic s);
    pull = !b;
    #400 scl = 1'b1;
    #390 s = sda;
    #10 scl = 1'b0;
  endtask

  // A rival device with a lower address is emulated by pulling its zero bits.
  task automatic ara(input logic [7:0] adr, input logic [7:0] rival,
                     output logic [7:0] got, output logic ack);
    logic s;
    #33 pull = 1'b1;
    #400 scl = 1'b0;
    for (int i = 7; i >= 0; i--)
      bit_io(adr[i], s);
    bit_io(1'b1, ack);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(rival[i], s);
      got[i] = s;
    end
    bit_io(1'b1, s);
    pull = 1'b1;
    #400 scl = 1'b1;
    #400 pull = 1'b0;
  endtask
endmodule

`default_nettype wire

// *** tb/fwa_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "fwa_cfg.svh"

module fwa_top_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [`FWA_FLT_N-1:0] fault_pin,
  input wire logic smb_sda_oe,
  input wire logic smb_sda_out,
  input wire logic first_alert_output_out,
  input wire logic first_alert_output_oe,
  input wire logic second_alert_output_out,
  input wire logic second_alert_output_oe,
  input wire logic hs_gate_on
);
  logic [1:0] inv_q;
  logic m1_q;
  logic m2_q;
  logic acc_wr;
  logic act1;
  logic act2;
  assign acc_wr = psel && penable && pwrite;
  assign act1 = first_alert_output_oe ^ inv_q[0];
  assign act2 = second_alert_output_oe ^ inv_q[1];

  // Shadow copy of the inversion register and any-bit-set flags of both mask registers, taken from bus writes.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      inv_q <= 2'b00;
      m1_q <= 1'b0;
      m2_q <= 1'b0;
    end
    else if (acc_wr)
    begin
      if (paddr == `FWA_A_ACTL)
        inv_q <= pwdata[1:0];
      if (paddr == `FWA_A_MASK1)
        m1_q <= |pwdata[14:0];
      if (paddr == `FWA_A_MASK2)
        m2_q <= |pwdata[14:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_clear;
    acc_wr && paddr == `FWA_A_CLEAR;
  endsequence
  sequence s_quiet;
    !act1 && !act2;
  endsequence

  a_reset_float: assert property (disable iff (1'b0) srst |=> s_quiet)
    else $error("alert pin driven after reset");
  a_pins_low: assert property (
    !first_alert_output_out && !second_alert_output_out && !smb_sda_out)
    else $error("alert pin drives a high level");
  a_fault_off: assert property ((fault_pin != 0) [*4] |-> !hs_gate_on)
    else $error("hot swap stays on during fault");
  a_drop_together: assert property ($fell(act1) || $fell(act2) |-> s_quiet)
    else $error("alerts released apart");
  a_clear_drops: assert property (s_clear |-> ##2 s_quiet)
    else $error("alert kept after clear");
  a_mask1_needed: assert property ($rose(act1) |-> m1_q)
    else $error("first alert without enable");
  a_mask2_needed: assert property ($rose(act2) |-> m2_q)
    else $error("second alert without enable");
  a_answer_alert: assert property ($rose(smb_sda_oe) |-> act1 || act2)
    else $error("response driven without alert");
  a_bad_write: assert property (acc_wr && paddr == `FWA_A_STATUS |-> pslverr)
    else $error("status write not refused");
  a_zero_wait: assert property (pready == (psel && penable))
    else $error("bus ready out of access");
endmodule

bind fwa_top fwa_top_asserts fwa_top_asserts_inst (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .fault_pin(fault_pin), .smb_sda_oe(smb_sda_oe),
  .smb_sda_out(smb_sda_out),
  .first_alert_output_out(first_alert_output_out),
  .first_alert_output_oe(first_alert_output_oe),
  .second_alert_output_out(second_alert_output_out),
  .second_alert_output_oe(second_alert_output_oe), .hs_gate_on(hs_gate_on));

`default_nettype wire

// *** tb/fwa_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "fwa_cfg.svh"

module fwa_top_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [`FWA_FLT_N-1:0] fault_pin = '0;
  logic brk = 1'b0;
  logic hyst = 1'b0;
  logic mon_sample = 1'b0;
  logic [11:0] vin = 12'h800;
  logic [11:0] vout = 12'h800;
  logic [11:0] iout = 12'h800;
  logic [31:0] prdata;
  logic pready, pslverr, gate, scl, sda, sda_oe, a1_oe, a2_oe;
  int n_mismatch = 0;
  int checked = 0;
  int cyc_n = 0;
  logic [31:0] r;
  logic e;
  logic [7:0] got;
  logic ack;

  fwa_top fwa_top_inst (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_pin(fault_pin), .breaker_trip_flag(brk),
    .hyst_warn_pin(hyst), .mon_sample(mon_sample), .input_voltage_reading(vin),
    .output_voltage_reading(vout), .load_current_reading(iout),
    .mon_temp_reading(12'h000), .mon_power_reading(16'h0000), .smb_scl(scl),
    .smb_sda_in(sda), .smb_sda_out(), .smb_sda_oe(sda_oe), .first_alert_output_out(),
    .first_alert_output_oe(a1_oe), .second_alert_output_out(),
    .second_alert_output_oe(a2_oe), .hs_gate_on(gate));
  fwa_host fwa_host_inst (.sda_oe(sda_oe), .scl(scl), .sda(sda));

  initial
  begin
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, r, exp);
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic pulse(input logic [4:0] f);
    @(posedge clk);
    fault_pin <= f;
    look(4);
    @(posedge clk);
    fault_pin <= '0;
    look(4);
  endtask

  task automatic sample(input logic [11:0] v);
    @(posedge clk);
    vout <= v;
    mon_sample <= 1'b1;
    @(posedge clk);
    mon_sample <= 1'b0;
    look(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("oe1", a1_oe, 0);
    chk("oe2", a2_oe, 0);
    chk("gate", gate, 1);
    rdc("oper", `FWA_A_OPER, 32'h80);
    rdc("mask1", `FWA_A_MASK1, 0);
    rdc("mask2", `FWA_A_MASK2, 0);
    rdc("mon", `FWA_A_MON, 32'hf);
    rdc("own", `FWA_A_OWN, 32'h2a);
    rdc("status", `FWA_A_STATUS, 0);
    $display("test reset done");
  endtask

  task automatic t_fault();
    for (int i = 0; i < `FWA_FLT_N; i++)
    begin
      @(posedge clk);
      fault_pin <= 5'h01 << i;
      look(5);
      chk("gate", gate, 0);
      @(posedge clk);
      fault_pin <= '0;
      look(4);
      rdc("status", `FWA_A_STATUS, 32'h1 << i);
      chk("oe2", a2_oe, 0);
      if (i == 4)
      begin
        apb(1'b1, `FWA_A_OPER, 32'h0);
        apb(1'b1, `FWA_A_OPER, 32'h80);
      end
      else
        apb(1'b1, `FWA_A_CLEAR, 32'h0);
      look(3);
      rdc("status", `FWA_A_STATUS, 0);
    end
    $display("test fault done");
  endtask

  task automatic t_persist();
    apb(1'b1, `FWA_A_MASK2, 32'h1);
    @(posedge clk);
    fault_pin <= 5'h01;
    look(5);
    chk("oe2", a2_oe, 1);
    chk("oe1", a1_oe, 0);
    apb(1'b1, `FWA_A_CLEAR, 32'h0);
    look(4);
    chk("oe2", a2_oe, 0);
    rdc("status", `FWA_A_STATUS, 1);
    chk("oe2", a2_oe, 0);
    @(posedge clk);
    fault_pin <= '0;
    look(4);
    apb(1'b1, `FWA_A_CLEAR, 32'h0);
    look(3);
    rdc("status", `FWA_A_STATUS, 0);
    chk("gate", gate, 1);
    apb(1'b1, `FWA_A_MASK2, 32'h0);
    $display("test persist done");
  endtask

  task automatic t_warn();
    @(posedge clk);
    brk <= 1'b1;
    hyst <= 1'b1;
    look(5);
    chk("gate", gate, 1);
    rdc("status", `FWA_A_STATUS, 32'h4040);
    @(posedge clk);
    brk <= 1'b0;
    hyst <= 1'b0;
    apb(1'b1, `FWA_A_STATUS, 32'h0);
    chk("err", e, 1);
    rdc("status", `FWA_A_STATUS, 32'h4060);
    apb(1'b1, `FWA_A_CLEAR, 32'h0);
    look(3);
    rdc("status", `FWA_A_STATUS, 0);
    $display("test warn done");
  endtask

  task automatic t_mon();
    apb(1'b1, `FWA_A_LIM0 + 8'h0c, 32'h100);
    apb(1'b1, `FWA_A_MASK2, 32'h400);
    apb(1'b1, `FWA_A_MON, 32'hd);
    sample(12'h0ff);
    chk("oe2", a2_oe, 0);
    apb(1'b1, `FWA_A_MON, 32'hf);
    sample(12'h100);
    chk("oe2", a2_oe, 0);
    sample(12'h0ff);
    chk("oe2", a2_oe, 1);
    rdc("vout", `FWA_A_RD0 + 8'h04, 32'h0ff);
    rdc("iout", `FWA_A_RD0 + 8'h08, 32'h800);
    apb(1'b1, `FWA_A_CLEAR, 32'h0);
    look(3);
    chk("oe2", a2_oe, 0);
    sample(12'h0ff);
    chk("oe2", a2_oe, 1);
    sample(12'h800);
    apb(1'b1, `FWA_A_CLEAR, 32'h0);
    apb(1'b1, `FWA_A_MASK2, 32'h0);
    look(3);
    rdc("status", `FWA_A_STATUS, 0);
    $display("test monitor done");
  endtask

  task automatic t_inv();
    apb(1'b1, `FWA_A_ACTL, 32'h3);
    look(1);
    chk("oe1", a1_oe, 1);
    chk("oe2", a2_oe, 1);
    rdc("actl", `FWA_A_ACTL, 32'h3);
    apb(1'b1, `FWA_A_ACTL, 32'h0);
    look(1);
    chk("oe1", a1_oe, 0);
    chk("oe2", a2_oe, 0);
    $display("test invert done");
  endtask

  task automatic t_ara();
    apb(1'b1, `FWA_A_MASK1, 32'h2);
    pulse(5'h02);
    chk("oe1", a1_oe, 1);
    fwa_host_inst.ara(8'h19, 8'h41, got, ack);
    look(8);
    chk("ack", ack, 0);
    chk("lost", got, 32'h41);
    chk("oe1", a1_oe, 1);
    fwa_host_inst.ara(8'h19, 8'hff, got, ack);
    look(8);
    chk("addr", got[7:1], 32'h2a);
    chk("oe1", a1_oe, 0);
    pulse(5'h02);
    chk("oe1", a1_oe, 0);
    apb(1'b1, `FWA_A_MASK1, 32'h6);
    pulse(5'h04);
    chk("oe1", a1_oe, 1);
    fwa_host_inst.ara(8'h31, 8'hff, got, ack);
    look(8);
    chk("ack", ack, 1);
    apb(1'b1, `FWA_A_CLEAR, 32'h0);
    apb(1'b1, `FWA_A_MASK1, 32'h0);
    look(3);
    chk("oe1", a1_oe, 0);
    $display("test ara done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    look(3);
    t_reset();
    t_fault();
    t_persist();
    t_warn();
    t_mon();
    t_inv();
    t_ara();
    report_and_stop();
  end
endmodule

`default_nettype wire
